// ===== src/so_uart_params.svh
// Timing constants, register offsets and bit positions for the single octet line link.
// Assumes a 125 MHz pclk and the fast line rate of 230.4 kBd.
`ifndef SO_UART_PARAMS_SVH
`define SO_UART_PARAMS_SVH
`define CLK_HZ      125000000
`define BAUD        230400
`define BIT_CYC     (`CLK_HZ / `BAUD)
`define SUB_CYC     (`BIT_CYC / 16)
`define SAMPLE_PH   4'h7
`define LAST_PH     4'hf
`define N_STOP      4'ha
`define N_GUARD     4'hb
`define GAP_TICKS   8'h40
`define REG_CTRL    8'h00
`define REG_STATUS  8'h04
`define REG_TXDATA  8'h08
`define REG_RXDATA  8'h0c
`define REG_CMD     8'h10
`define C_SGL       0
`define C_SIO       1
`define C_HS        2
`define C_LS        3
`define C_TRNS      4
`define C_SS        5
`define C_MOSI      6
`define CMD_END     0
`endif

// ===== src/so_uart_pkg.sv
// Types used by the transceiver end and the link checker of the single octet line link.
// Assumes nothing beyond the parameter header.
package so_uart_pkg;
	typedef enum logic [2:0]
	{
		ST_LISTEN     = 3'b000,
		ST_RX_WAIT    = 3'b001,
		ST_RX_INTERIM = 3'b010,
		ST_TX_WAIT    = 3'b011,
		ST_TX_EMPTY   = 3'b100,
		ST_TX_FULL    = 3'b101,
		ST_TX_TERM    = 3'b110
	} uart_state_t;
endpackage

// ===== src/so_link_if.sv
// Interface joining the host controller to the transceiver's control port.
// Assumes both ends run on the same pclk.
`timescale 1ns/100ps
`default_nettype none
interface so_link_if;
	logic       sgl;
	logic       sio;
	logic       hs;
	logic       ls;
	logic       trns;
	logic       ss;
	logic       mosi;
	logic [7:0] fb_wdata;
	logic       fb_wr;
	logic       fb_rd;
	logic       link_end;
	logic [7:0] fb_rdata;
	logic       dat;
	logic       chk;
	logic       ssc;
	logic       sot;
	logic       miso;
	logic [2:0] state;
	modport dev (input sgl, sio, hs, ls, trns, ss, mosi, fb_wdata, fb_wr, fb_rd, link_end,
		output fb_rdata, dat, chk, ssc, sot, miso, state);
	modport host (output sgl, sio, hs, ls, trns, ss, mosi, fb_wdata, fb_wr, fb_rd, link_end,
		input fb_rdata, dat, chk, ssc, sot, miso, state);
endinterface
`default_nettype wire

// ===== src/so_uart_dev.sv
// Transceiver end: single octet line UART, transparent path and short handling.
// Assumes the host end drives the control port on the same pclk; line pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "so_uart_params.svh"
module so_uart_dev
#(
	parameter int RETRY_CYC   = 1250000,
	parameter int SHORT_CYC   = 2500,
	parameter int RESTART_CYC = 2500000
)
(
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Control port toward the host.
	so_link_if.dev    lnk,
	// Line pin and fault sensors.
	input  wire logic line_in,
	output logic      line_out,
	output logic      line_oe_n,
	input  wire logic short_in,
	input  wire logic ot_in
);
	// ======================================================================
	// Input synchronisers
	// ======================================================================
	logic [2:0] raw;
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	assign raw = {ot_in, short_in, line_in};
	// Each asynchronous input passes two flops before any logic sees it.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
				end
				else
				begin
					s1_q[gi] <= raw[gi];
					s2_q[gi] <= s1_q[gi];
				end
			end
		end
	endgenerate

	// ======================================================================
	// Sub-bit tick and glitch filter
	// ======================================================================
	logic [5:0] sub_q;
	logic       tick;
	logic [5:0] flt_cnt_q;
	logic       filt_q;
	logic       rx_bit;
	assign tick   = (sub_q == 6'(`SUB_CYC - 1));
	assign rx_bit = ~filt_q; // A high line is a logic zero.
	// The filter delays every edge by the same sixteenth of a bit, so pulse widths survive.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sub_q     <= 6'h00;
			flt_cnt_q <= 6'h00;
			filt_q    <= 1'b0;
		end
		else
		begin
			sub_q <= tick ? 6'h00 : sub_q + 6'h01;
			if (s2_q[0] == filt_q)
				flt_cnt_q <= 6'h00;
			else if (flt_cnt_q == 6'(`SUB_CYC - 1))
			begin
				filt_q    <= s2_q[0];
				flt_cnt_q <= 6'h00;
			end
			else
				flt_cnt_q <= flt_cnt_q + 6'h01;
		end
	end

	// ======================================================================
	// Mode decode
	// ======================================================================
	so_uart_pkg::uart_state_t st_q;
	so_uart_pkg::uart_state_t st_d;
	logic fsm_on;
	logic sw_listen;
	logic rx_state;
	assign fsm_on    = lnk.sgl & ~lnk.trns;
	assign sw_listen = lnk.sio & ~lnk.hs & ~lnk.ls;
	assign rx_state  = (st_q == so_uart_pkg::ST_LISTEN) | (st_q == so_uart_pkg::ST_RX_WAIT) |
		(st_q == so_uart_pkg::ST_RX_INTERIM);

	// ======================================================================
	// Receiver
	// ======================================================================
	logic       rx_act_q;
	logic [3:0] rx_ph_q;
	logic [3:0] rx_n_q;
	logic [9:0] rx_sh_q;
	logic       rx_done_q;
	logic [7:0] gap_q;
	logic       gap_arm_q;
	logic       rx_smp;
	logic       rx_err;
	logic       rx_rep;
	logic       to_ev;
	assign rx_smp = rx_act_q & tick & (rx_ph_q == `SAMPLE_PH);
	assign rx_err = (^rx_sh_q[8:0]) | ~rx_sh_q[9]; // Even parity and stop bit.
	assign rx_rep = rx_done_q & fsm_on & rx_state & ~(sw_listen & rx_err);
	assign to_ev  = gap_arm_q & tick & (gap_q == `GAP_TICKS - 8'h01);
	// Frames are sampled mid-bit; the receiver runs in every receive state.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_act_q  <= 1'b0;
			rx_ph_q   <= 4'h0;
			rx_n_q    <= 4'h0;
			rx_sh_q   <= 10'h000;
			rx_done_q <= 1'b0;
		end
		else
		begin
			rx_done_q <= 1'b0;
			if (!fsm_on)
				rx_act_q <= 1'b0;
			else if (!rx_act_q)
			begin
				if (!rx_bit)
				begin
					rx_act_q <= 1'b1;
					rx_ph_q  <= 4'h0;
					rx_n_q   <= 4'h0;
				end
			end
			else if (tick)
			begin
				rx_ph_q <= rx_ph_q + 4'h1;
				if (rx_smp)
				begin
					rx_n_q <= rx_n_q + 4'h1;
					if (rx_n_q == 4'h0)
						rx_act_q <= ~rx_bit;
					else
						rx_sh_q <= {rx_bit, rx_sh_q[9:1]};
					if (rx_n_q == `N_STOP)
					begin
						rx_act_q  <= 1'b0;
						rx_done_q <= 1'b1;
					end
				end
			end
		end
	end
	// A gap longer than four bits after an octet counts as a time-out.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gap_q     <= 8'h00;
			gap_arm_q <= 1'b0;
		end
		else
		begin
			if (rx_rep)
				gap_arm_q <= 1'b1;
			else if (rx_act_q | to_ev | ~rx_state | ~fsm_on)
				gap_arm_q <= 1'b0;
			if (!gap_arm_q | rx_act_q)
				gap_q <= 8'h00;
			else if (tick)
				gap_q <= gap_q + 8'h01;
		end
	end

	// ======================================================================
	// Transmitter
	// ======================================================================
	logic       tx_act_q;
	logic [3:0] tx_ph_q;
	logic [3:0] tx_n_q;
	logic [9:0] tx_sh_q;
	logic       tx_done;
	logic       tx_load;
	logic [7:0] tx_src;
	logic [7:0] buf_q;
	logic       in_rx_wait;
	assign in_rx_wait = (st_q == so_uart_pkg::ST_RX_WAIT) | (st_q == so_uart_pkg::ST_RX_INTERIM);
	assign tx_done = tx_act_q & tick & (tx_ph_q == `LAST_PH) & (tx_n_q == `N_GUARD);
	assign tx_load = fsm_on & ((lnk.fb_wr & (in_rx_wait | (st_q == so_uart_pkg::ST_TX_WAIT))) |
		(tx_done & (st_q == so_uart_pkg::ST_TX_FULL)));
	assign tx_src  = (st_q == so_uart_pkg::ST_TX_FULL) ? buf_q : lnk.fb_wdata;
	// Shift order: start, eight data LSB first, parity, stop, then one idle guard bit.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_act_q <= 1'b0;
			tx_ph_q  <= 4'h0;
			tx_n_q   <= 4'h0;
			tx_sh_q  <= 10'h3ff;
		end
		else if (!fsm_on)
			tx_act_q <= 1'b0;
		else if (tx_load)
		begin
			tx_act_q <= 1'b1;
			tx_ph_q  <= 4'h0;
			tx_n_q   <= 4'h0;
			tx_sh_q  <= {1'b1, ^tx_src, tx_src};
		end
		else if (tx_act_q & tick)
		begin
			tx_ph_q <= tx_ph_q + 4'h1;
			if (tx_ph_q == `LAST_PH)
			begin
				tx_n_q <= tx_n_q + 4'h1;
				if (tx_n_q != 4'h0)
					tx_sh_q <= {1'b1, tx_sh_q[9:1]};
				if (tx_n_q == `N_GUARD)
					tx_act_q <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Single octet state machine
	// ======================================================================
	always_comb
	begin
		st_d = st_q;
		case (st_q)
			so_uart_pkg::ST_LISTEN:
				if (rx_rep)
					st_d = so_uart_pkg::ST_RX_WAIT;
			so_uart_pkg::ST_RX_WAIT, so_uart_pkg::ST_RX_INTERIM:
				if (lnk.fb_wr)
					st_d = so_uart_pkg::ST_TX_EMPTY;
				else if (rx_rep)
					st_d = so_uart_pkg::ST_RX_WAIT;
				else if (lnk.link_end)
					st_d = so_uart_pkg::ST_LISTEN;
				else if (lnk.fb_rd)
					st_d = so_uart_pkg::ST_RX_INTERIM;
			so_uart_pkg::ST_TX_WAIT:
				if (lnk.fb_wr)
					st_d = so_uart_pkg::ST_TX_EMPTY;
				else if (lnk.link_end)
					st_d = so_uart_pkg::ST_LISTEN;
			so_uart_pkg::ST_TX_EMPTY:
				if (lnk.fb_wr)
					st_d = so_uart_pkg::ST_TX_FULL;
				else if (lnk.link_end)
					st_d = so_uart_pkg::ST_TX_TERM;
				else if (tx_done)
					st_d = so_uart_pkg::ST_TX_WAIT;
			so_uart_pkg::ST_TX_FULL:
				if (tx_done)
					st_d = so_uart_pkg::ST_TX_EMPTY;
			so_uart_pkg::ST_TX_TERM:
				if (tx_done)
					st_d = so_uart_pkg::ST_LISTEN;
			default:
				st_d = so_uart_pkg::ST_LISTEN;
		endcase
		if (!fsm_on)
			st_d = so_uart_pkg::ST_LISTEN;
	end

	// ======================================================================
	// Flags and frame buffer
	// ======================================================================
	logic dat_set;
	logic chk_set;
	logic flag_clr;
	logic underrun;
	assign underrun = tx_done & (st_q == so_uart_pkg::ST_TX_EMPTY) & ~lnk.fb_wr & ~lnk.link_end;
	// A new empty buffer requests the next octet at once, even mid-frame.
	assign dat_set  = rx_rep | to_ev | ((st_d != st_q) & ((st_d == so_uart_pkg::ST_TX_EMPTY) |
		(st_d == so_uart_pkg::ST_TX_WAIT)));
	assign chk_set  = (rx_rep & (rx_err | (st_q == so_uart_pkg::ST_RX_WAIT))) |
		(to_ev & ~lnk.fb_wr) | underrun;
	assign flag_clr = lnk.fb_wr | lnk.link_end | ~fsm_on;
	// Set wins over clear so an event in the clearing cycle is kept.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q          <= so_uart_pkg::ST_LISTEN;
			lnk.dat       <= 1'b0;
			lnk.chk       <= 1'b0;
			lnk.fb_rdata  <= 8'h00;
			buf_q         <= 8'h00;
		end
		else
		begin
			st_q <= st_d;
			if (dat_set & fsm_on)
				lnk.dat <= 1'b1;
			else if (flag_clr)
				lnk.dat <= 1'b0;
			if (chk_set & fsm_on)
				lnk.chk <= 1'b1;
			else if (flag_clr)
				lnk.chk <= 1'b0;
			if (rx_rep)
				lnk.fb_rdata <= rx_sh_q[7:0];
			if (lnk.fb_wr & (st_q == so_uart_pkg::ST_TX_EMPTY))
				buf_q <= lnk.fb_wdata;
		end
	end
	assign lnk.state = st_q;

	// ======================================================================
	// Output drive, transparent path and short handling
	// ======================================================================
	logic        mosi_lat_q;
	logic        mosi_eff;
	logic        want_lvl;
	logic        want_drv;
	logic        tx_lvl;
	logic [23:0] sc_cnt_q;
	logic [23:0] rs_cnt_q;
	logic        off_q;
	logic [23:0] sc_lim;
	logic        tr_listen;
	assign mosi_eff  = lnk.ss ? lnk.mosi : mosi_lat_q;
	assign tx_lvl    = (tx_n_q == 4'h0) ? 1'b1 : ((tx_n_q == `N_GUARD) ? 1'b0 : ~tx_sh_q[0]);
	assign tr_listen = ~lnk.hs & ~lnk.ls;
	assign want_lvl  = lnk.trns ? ~mosi_eff : tx_lvl;
	// Unused link-mode codes leave the line undriven; faults drop octets silently.
	assign want_drv  = ~off_q & ~s2_q[2] & (lnk.trns ?
		((lnk.hs & lnk.ls) | (lnk.sio & ((lnk.hs & want_lvl) | (lnk.ls & ~want_lvl)))) :
		(tx_act_q & (tx_n_q != `N_GUARD)));
	assign sc_lim    = (lnk.trns & ~lnk.sio) ? 24'(SHORT_CYC) : 24'(RETRY_CYC);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mosi_lat_q <= 1'b1;
			line_out   <= 1'b0;
			line_oe_n  <= 1'b1;
			lnk.miso   <= 1'b0;
			lnk.sot    <= 1'b0;
		end
		else
		begin
			if (lnk.ss)
				mosi_lat_q <= lnk.mosi;
			line_out  <= want_lvl;
			line_oe_n <= ~want_drv;
			lnk.miso  <= lnk.ss & lnk.trns & ~filt_q;
			lnk.sot   <= s2_q[2];
		end
	end
	// A short must persist for the mode's detect time before it is reported.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sc_cnt_q <= 24'h00_0000;
			rs_cnt_q <= 24'h00_0000;
			off_q    <= 1'b0;
			lnk.ssc  <= 1'b0;
		end
		else if (lnk.trns & tr_listen)
		begin
			sc_cnt_q <= 24'h00_0000;
			rs_cnt_q <= 24'h00_0000;
			off_q    <= 1'b0;
			lnk.ssc  <= 1'b0;
		end
		else if (off_q)
		begin
			rs_cnt_q <= rs_cnt_q + 24'h00_0001;
			if (rs_cnt_q == 24'(RESTART_CYC - 1))
			begin
				off_q    <= 1'b0;
				rs_cnt_q <= 24'h00_0000;
			end
		end
		else if (s2_q[1] & ~line_oe_n)
		begin
			sc_cnt_q <= sc_cnt_q + 24'h00_0001;
			if (sc_cnt_q == sc_lim - 24'h00_0001)
			begin
				lnk.ssc  <= 1'b1;
				off_q    <= 1'b1;
				sc_cnt_q <= 24'h00_0000;
			end
		end
		else if (!s2_q[1])
		begin
			sc_cnt_q <= 24'h00_0000;
			lnk.ssc  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== src/so_uart_host.sv
// Host end: APB slave registers that steer the transceiver's control port.
// Assumes an APB master on pclk; zero wait states.
`timescale 1ns/100ps
`default_nettype none
`include "so_uart_params.svh"
module so_uart_host
(
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Control port toward the transceiver.
	so_link_if.host          lnk
);
	// ======================================================================
	// Address decode
	// ======================================================================
	logic       setup;
	logic       acc;
	logic       hit_ctrl;
	logic       hit_stat;
	logic       hit_tx;
	logic       hit_rx;
	logic       hit_cmd;
	logic       hit_any;
	logic [6:0] ctrl_q;
	logic [31:0] rd_mux;
	assign setup    = psel & ~penable;
	assign acc      = psel & penable & pready;
	assign hit_ctrl = (paddr == `REG_CTRL);
	assign hit_stat = (paddr == `REG_STATUS);
	assign hit_tx   = (paddr == `REG_TXDATA);
	assign hit_rx   = (paddr == `REG_RXDATA);
	assign hit_cmd  = (paddr == `REG_CMD);
	assign hit_any  = hit_ctrl | hit_stat | hit_tx | hit_rx | hit_cmd;
	// Status shows the transceiver's live flags and state machine.
	assign rd_mux   = hit_ctrl ? {25'h000_0000, ctrl_q} :
		hit_stat ? {24'h00_0000, lnk.state, lnk.miso, lnk.sot, lnk.ssc, lnk.chk, lnk.dat} :
		hit_rx ? {24'h00_0000, lnk.fb_rdata} : 32'h0000_0000;

	// ======================================================================
	// Bus answer
	// ======================================================================
	// Read data and error are prepared in the setup cycle so the access phase ends at once.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= 1'b1;
			if (setup)
			begin
				prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr <= ~hit_any;
			end
		end
	end

	// ======================================================================
	// Control register and command strobes
	// ======================================================================
	// Strobes last one cycle; a buffer write and a link end may not be merged.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q        <= 7'h60;
			lnk.fb_wdata  <= 8'h00;
			lnk.fb_wr     <= 1'b0;
			lnk.fb_rd     <= 1'b0;
			lnk.link_end  <= 1'b0;
		end
		else
		begin
			lnk.fb_wr    <= acc & pwrite & hit_tx;
			lnk.fb_rd    <= acc & ~pwrite & hit_rx;
			lnk.link_end <= acc & pwrite & hit_cmd & pwdata[`CMD_END];
			if (acc & pwrite & hit_tx)
				lnk.fb_wdata <= pwdata[7:0];
			if (acc & pwrite & hit_ctrl)
				ctrl_q <= pwdata[6:0];
		end
	end
	assign lnk.sgl  = ctrl_q[`C_SGL];
	assign lnk.sio  = ctrl_q[`C_SIO];
	assign lnk.hs   = ctrl_q[`C_HS];
	assign lnk.ls   = ctrl_q[`C_LS];
	assign lnk.trns = ctrl_q[`C_TRNS];
	assign lnk.ss   = ctrl_q[`C_SS];
	assign lnk.mosi = ctrl_q[`C_MOSI];
endmodule
`default_nettype wire

// ===== tb/so_link_chk.sv
// Checker for the control port that joins the host end to the transceiver end.
// Assumes one pclk domain and an active low asynchronous presetn.
`timescale 1ns/100ps
`default_nettype none
module so_link_chk
(
	// Clock and reset.
	input wire logic       pclk,
	input wire logic       presetn,
	// Watched link signals.
	input wire logic       fb_wr,
	input wire logic       fb_rd,
	input wire logic       link_end,
	input wire logic       dat,
	input wire logic       ss,
	input wire logic       trns,
	input wire logic       miso,
	input wire logic [2:0] state
);
	// ==========================================================
	// State sequencing, request flag and miso gating of the single octet machine.
	// ==========================================================
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_read_interim:
		assert property (fb_rd && state == so_uart_pkg::ST_RX_WAIT |-> ##[1:3] state == so_uart_pkg::ST_RX_INTERIM)
		else $error("buffer read left receive wait untouched");
	chk_write_starts:
		assert property (fb_wr && state inside {so_uart_pkg::ST_RX_WAIT, so_uart_pkg::ST_RX_INTERIM,
			so_uart_pkg::ST_TX_WAIT} |-> ##[1:3] state == so_uart_pkg::ST_TX_EMPTY)
		else $error("buffer write did not start sending");
	chk_write_fills:
		assert property (fb_wr && state == so_uart_pkg::ST_TX_EMPTY |-> ##[1:3] state == so_uart_pkg::ST_TX_FULL)
		else $error("buffer write did not fill the buffer");
	chk_end_terms:
		assert property (link_end && state == so_uart_pkg::ST_TX_EMPTY |-> ##[1:3] state == so_uart_pkg::ST_TX_TERM)
		else $error("link end did not terminate");
	chk_tx_after_rx:
		assert property ($rose(state == so_uart_pkg::ST_TX_EMPTY) |-> $past(state) != so_uart_pkg::ST_LISTEN)
		else $error("sending began without a received octet");
	chk_term_idle:
		assert property (state == so_uart_pkg::ST_TX_TERM |=> state inside {so_uart_pkg::ST_TX_TERM,
			so_uart_pkg::ST_LISTEN})
		else $error("terminating left to a wrong state");
	chk_full_empty:
		assert property (state == so_uart_pkg::ST_TX_FULL |=> state inside {so_uart_pkg::ST_TX_FULL,
			so_uart_pkg::ST_TX_EMPTY})
		else $error("full buffer left to a wrong state");
	chk_trns_hold:
		assert property (trns [*3] |-> state == so_uart_pkg::ST_LISTEN)
		else $error("link machine runs in transparent mode");
	chk_rx_flag:
		assert property (state == so_uart_pkg::ST_LISTEN ##1 state == so_uart_pkg::ST_RX_WAIT |-> ##[0:2] dat)
		else $error("received octet not flagged");
	chk_tx_request:
		assert property ($rose(state == so_uart_pkg::ST_TX_EMPTY) |-> ##[0:2] dat)
		else $error("empty buffer did not request an octet");
	chk_miso_frozen:
		assert property (!ss |=> !miso)
		else $error("line level shown while select is low");
	// Main scenarios seen at least once.
	cover property (state == so_uart_pkg::ST_TX_FULL);
	cover property (state == so_uart_pkg::ST_TX_TERM ##1 state == so_uart_pkg::ST_LISTEN);
	cover property (fb_rd);
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Testbench for both ends of the single octet link, APB on one side, line on the other.
// Assumes the parameter header and the package are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "so_uart_params.svh"
module tb_top;
	// ==========================================================
	// Signals, instances and clock.
	// ==========================================================
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        line_in = 1'b0;
	logic        line_out;
	logic        line_oe_n;
	logic        short_in = 1'b0;
	logic        ot_in = 1'b0;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	so_link_if lnk();
	so_uart_dev #(.RETRY_CYC(50), .SHORT_CYC(20), .RESTART_CYC(50)) i_so_uart_dev (.pclk(pclk),
		.presetn(presetn), .lnk(lnk), .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n),
		.short_in(short_in), .ot_in(ot_in));
	so_uart_host i_so_uart_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lnk(lnk));
	so_link_chk i_so_link_chk (.pclk(pclk), .presetn(presetn), .fb_wr(lnk.fb_wr), .fb_rd(lnk.fb_rd),
		.link_end(lnk.link_end), .dat(lnk.dat), .ss(lnk.ss), .trns(lnk.trns), .miso(lnk.miso),
		.state(lnk.state));
	// The clock toggles every half period of 4 ns.
	always #4 pclk = ~pclk;
	// A hang is cut short well above the expected run of about 46000 cycles.
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			n_errors++;
			$display("mismatch at %0t: run timed out", $time);
			results();
		end
	end
	// ==========================================================
	// Shared tasks.
	// ==========================================================
	task automatic results();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the request holds until pready is seen at an edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic er);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the bench timeout ends a wait for a slave that never answers.
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        er;
		apb(1'b1, a, d, q, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] q;
		logic        er;
		apb(1'b0, a, 32'h0000_0000, q, er);
		check(q & m, e);
	endtask
	// Master frame: start, data LSB first, even parity, stop; logic one is a low level.
	task automatic send(input logic [7:0] b, input logic perr);
		logic [10:0] f;
		f = {1'b1, ^b ^ perr, b, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			line_in <= ~f[i];
			repeat (528) @(posedge pclk);
		end
	endtask
	// Captures one sent frame at bit centres; gap counts idle cycles since the last stop centre.
	task automatic grab(input logic [7:0] e, input logic gap);
		logic [10:0] f;
		int          n;
		n = 0;
		while (!(line_out === 1'b1 && line_oe_n === 1'b0) && n < 20000)
		begin
			@(posedge pclk);
			n++;
		end
		if (gap)
			check(n >= 16 * `SUB_CYC, 1'b1);
		repeat (264) @(posedge pclk);
		for (int i = 0; i < 11; i++)
		begin
			f[i] = ~line_out;
			if (i < 10)
				repeat (528) @(posedge pclk);
		end
		check(f, {1'b1, ^e, e, 1'b0});
	endtask
	// ==========================================================
	// Scenarios.
	// ==========================================================
	task automatic sc_regs();
		logic [31:0] q;
		logic        er;
		rd(`REG_CTRL, 32'h0000_0060, 32'hffff_ffff);
		apb(1'b0, 8'h40, 32'h0000_0000, q, er);
		check(q, 32'h0000_0000);
		check(er, 32'h0000_0001);
	endtask
	task automatic sc_rx_tx();
		wr(`REG_CTRL, 32'h0000_0061);
		send(8'ha5, 1'b0);
		repeat (600) @(posedge pclk);
		rd(`REG_STATUS, 32'h0000_0021, 32'h0000_00ef);
		rd(`REG_RXDATA, 32'h0000_00a5, 32'h0000_00ff);
		rd(`REG_STATUS, 32'h0000_0041, 32'h0000_00ef);
		wr(`REG_TXDATA, 32'h0000_003c);
		rd(`REG_STATUS, 32'h0000_0081, 32'h0000_00ef);
		grab(8'h3c, 1'b0);
		repeat (1000) @(posedge pclk);
		rd(`REG_STATUS, 32'h0000_0063, 32'h0000_00ef);
		wr(`REG_TXDATA, 32'h0000_0081);
		wr(`REG_TXDATA, 32'h0000_0042);
		rd(`REG_STATUS, 32'h0000_00a0, 32'h0000_00e0);
		grab(8'h81, 1'b0);
		fork
			grab(8'h42, 1'b1);
			begin
				repeat (800) @(posedge pclk);
				wr(`REG_CMD, 32'h0000_0001);
				rd(`REG_STATUS, 32'h0000_00c0, 32'h0000_00e0);
			end
		join
		repeat (1000) @(posedge pclk);
		rd(`REG_STATUS, 32'h0000_0000, 32'h0000_00e0);
		check(line_oe_n, 1'b1);
	endtask
	task automatic sc_parity();
		send(8'h5a, 1'b1);
		repeat (600) @(posedge pclk);
		rd(`REG_STATUS, 32'h0000_0003, 32'h0000_0003);
		wr(`REG_CMD, 32'h0000_0001);
		rd(`REG_STATUS, 32'h0000_0000, 32'h0000_0003);
	endtask
	task automatic sc_fault();
		int drove;
		drove = 0;
		wr(`REG_CTRL, 32'h0000_0071);
		wr(`REG_CTRL, 32'h0000_0061);
		rd(`REG_STATUS, 32'h0000_0000, 32'h0000_00e0);
		send(8'h0f, 1'b0);
		repeat (600) @(posedge pclk);
		ot_in <= 1'b1;
		rd(`REG_RXDATA, 32'h0000_000f, 32'h0000_00ff);
		wr(`REG_TXDATA, 32'h0000_0055);
		repeat (50) @(posedge pclk);
		rd(`REG_STATUS, 32'h0000_0089, 32'h0000_00e9);
		repeat (7000) @(posedge pclk)
			if (line_oe_n !== 1'b1)
				drove = 1;
		check(drove, 0);
		rd(`REG_STATUS, 32'h0000_0069, 32'h0000_00e9);
		wr(`REG_CMD, 32'h0000_0001);
		ot_in <= 1'b0;
	endtask
	task automatic sc_trans();
		for (int i = 0; i < 8; i++)
		begin
			wr(`REG_CTRL, {24'h00_0000, 4'h7, i[0], i[1], i[2], 1'b0});
			repeat (5) @(posedge pclk);
			if (!(i[2] && (i[1] ^ i[0])))
				check(line_oe_n, !(i[1] && i[0]));
		end
		check(line_out, 1'b0);
		wr(`REG_CTRL, 32'h0000_003c);
		repeat (5) @(posedge pclk);
		check(line_out, 1'b1);
		wr(`REG_CTRL, 32'h0000_005c);
		repeat (5) @(posedge pclk);
		check(line_out, 1'b1);
		wr(`REG_CTRL, 32'h0000_007c);
		repeat (50) @(posedge pclk);
		check(lnk.miso, 1'b1);
		line_in <= 1'b1;
		repeat (20) @(posedge pclk);
		check(lnk.miso, 1'b1);
		repeat (30) @(posedge pclk);
		check(lnk.miso, 1'b0);
		line_in <= 1'b0;
		wr(`REG_CTRL, 32'h0000_005c);
		repeat (50) @(posedge pclk);
		check(lnk.miso, 1'b0);
	endtask
	task automatic sc_short();
		int n;
		n = 0;
		wr(`REG_CTRL, 32'h0000_007c);
		short_in <= 1'b1;
		while (lnk.ssc !== 1'b1 && n < 300)
		begin
			@(posedge pclk);
			n++;
		end
		check(n >= 20 && n < 300, 1'b1);
		// The enable is registered, so it turns off one cycle after the flag rises.
		@(posedge pclk);
		check(line_oe_n, 1'b1);
		short_in <= 1'b0;
		wr(`REG_CTRL, 32'h0000_0070);
		rd(`REG_STATUS, 32'h0000_0000, 32'h0000_0004);
		wr(`REG_CTRL, 32'h0000_0060);
	endtask
	// Reset for 20 cycles, then the scenarios in turn.
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		sc_regs();
		sc_rx_tx();
		sc_parity();
		sc_fault();
		sc_trans();
		sc_short();
		results();
	end
endmodule
`default_nettype wire
